// ==== pkg/move_exec_params.svh ====
// Purpose: Constants shared by the literal and indirect move execution logic.
// Assumes: Included by bare name from the interface, the design modules and the verification files.
// Notes: Definitions only; no logic lives here.
`ifndef MOVE_EXEC_PARAMS_SVH
`define MOVE_EXEC_PARAMS_SVH

// Pointer update mode encodings.
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3

// Field widths.
`define PTR_W 16
`define DATA_W 8
`define BANK_W 6
`define PAGE_W 7
`define OFFSET_W 6
`define PTR_COUNT 2

// Reset values.
`define PTR_RESET 16'h0000
`define ACC_RESET 8'h00
`define BANK_RESET 6'h00
`define PAGE_RESET 7'h00

`endif

// ==== pkg/move_exec_pkg.sv ====
// Purpose: Types shared by the move execution logic.
// Assumes: Decoding of the raw instruction word happens upstream.
// Notes: Mode codes and widths live in the params header.
package move_exec_pkg;
	// Instruction selected by the upstream decoder.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_LOAD_VIA_POINTER,
		OP_LOAD_BANK_LITERAL,
		OP_LOAD_PAGE_LITERAL,
		OP_LOAD_ACC_LITERAL
	} op_t;
endpackage

// ==== pkg/pointer_if.sv ====
// Purpose: Carries update, write and value signals between executor and pointer file.
// Assumes: All signals belong to the ref_clk domain.
// Notes: An update has priority over a plain write to the same pointer.
`include "move_exec_params.svh"
interface pointer_if;
	logic sel;
	logic upd_en;
	logic upd_inc;
	logic wr_en;
	logic wr_sel;
	logic [`PTR_W-1:0] wr_data;
	logic [`PTR_W-1:0] value [0:`PTR_COUNT-1];

	modport exec (output sel, output upd_en, output upd_inc, output wr_en, output wr_sel,
		output wr_data, input value);
	modport unit (input sel, input upd_en, input upd_inc, input wr_en, input wr_sel,
		input wr_data, output value);
endinterface

// ==== rtl/literal_indirect_move_exec.sv ====
// Purpose: Executes load-via-pointer and the three literal load instructions.
// Assumes: An upstream decoder presents one decoded instruction with instr_valid.
// Notes: Literal loads finish at the accept edge; the pointer load takes three cycles.
`include "move_exec_params.svh"
module literal_indirect_move_exec (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire move_exec_pkg::op_t instr_op,
	input wire logic ptr_select,
	input wire logic [1:0] update_mode,
	input wire logic offset_form,
	input wire logic [`OFFSET_W-1:0] offset,
	input wire logic [`DATA_W-1:0] literal,
	output logic mem_rd_en,
	output logic [`PTR_W-1:0] mem_addr,
	input wire logic [`DATA_W-1:0] mem_rd_data,
	input wire logic ptr_wr_en,
	input wire logic ptr_wr_sel,
	input wire logic [`PTR_W-1:0] ptr_wr_data,
	output logic [`PTR_W-1:0] pointer0,
	output logic [`PTR_W-1:0] pointer1,
	output logic [`DATA_W-1:0] accumulator,
	output logic [`BANK_W-1:0] bank_select_reg,
	output logic [`PAGE_W-1:0] program_counter_high_latch,
	output logic status_zero,
	output logic instr_done
);
	import move_exec_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_CAPTURE
	} state_t;

	state_t state_q;
	state_t state_d;
	logic [`PTR_W-1:0] addr_q;
	logic [`PTR_W-1:0] addr_d;
	logic rd_en_q;
	logic rd_en_d;
	logic sel_q;
	logic sel_d;
	logic upd_q;
	logic upd_d;
	logic inc_q;
	logic inc_d;
	logic [`DATA_W-1:0] acc_q;
	logic [`DATA_W-1:0] acc_d;
	logic [`BANK_W-1:0] bank_q;
	logic [`BANK_W-1:0] bank_d;
	logic [`PAGE_W-1:0] page_q;
	logic [`PAGE_W-1:0] page_d;
	logic zero_q;
	logic zero_d;
	logic done_q;
	logic done_d;

	// Pointer file shared with other logic; an update from this block beats their write.
	// Keeping the pointers here means the next instruction sees the moved value at once.
	pointer_if ptr_bus ();

	pointer_unit u_pointers (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus(ptr_bus)
	);

	// Instruction handshake and opcode decode.
	wire idle = (state_q == ST_IDLE);
	wire accept = instr_valid && idle;
	wire is_ptr_load = accept && (instr_op == OP_LOAD_VIA_POINTER);
	wire is_bank_lit = accept && (instr_op == OP_LOAD_BANK_LITERAL);
	wire is_page_lit = accept && (instr_op == OP_LOAD_PAGE_LITERAL);
	wire is_acc_lit = accept && (instr_op == OP_LOAD_ACC_LITERAL);
	wire capture = (state_q == ST_CAPTURE);

	// The held pointer is read directly from the pointer file at the accept edge.
	// A write landing on that same edge is too late for this address; it was fixed at take.
	wire [`PTR_W-1:0] base_ptr = ptr_bus.value[ptr_select];

	// Offset is sign-extended; the 16-bit sum wraps just like the pointer itself.
	wire [`PTR_W-1:0] offset_ext = {{(`PTR_W-`OFFSET_W){offset[`OFFSET_W-1]}}, offset};
	wire [`PTR_W-1:0] addr_plus = 16'(base_ptr + 16'h0001);
	wire [`PTR_W-1:0] addr_minus = 16'(base_ptr - 16'h0001);
	wire [`PTR_W-1:0] addr_offset = 16'(base_ptr + offset_ext);

	// Mode decode: pre modes address the moved pointer, post modes the old one.
	wire mode_pre_inc = (update_mode == `MODE_PRE_INC);
	wire mode_pre_dec = (update_mode == `MODE_PRE_DEC);
	wire mode_inc = (update_mode == `MODE_PRE_INC) || (update_mode == `MODE_POST_INC);
	wire [`PTR_W-1:0] eff_addr = offset_form ? addr_offset
		: mode_pre_inc ? addr_plus
		: mode_pre_dec ? addr_minus
		: base_ptr;

	// Sequencer: accept, drive the read, capture the returned byte.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (is_ptr_load) begin
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				state_d = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// The read request is a registered strobe so the address and enable line up.
	assign rd_en_d = is_ptr_load;
	assign addr_d = is_ptr_load ? eff_addr : addr_q;

	// Remember which pointer moves and which way; offset form never moves it.
	assign sel_d = is_ptr_load ? ptr_select : sel_q;
	assign upd_d = is_ptr_load ? !offset_form : upd_q;
	assign inc_d = is_ptr_load ? mode_inc : inc_q;

	// Accumulator takes the literal whole, or the fetched byte at capture.
	assign acc_d = is_acc_lit ? literal
		: capture ? mem_rd_data
		: acc_q;

	// Upper literal bits are expected zero, so they are simply dropped here.
	assign bank_d = is_bank_lit ? literal[`BANK_W-1:0] : bank_q;
	assign page_d = is_page_lit ? literal[`PAGE_W-1:0] : page_q;

	// Only the pointer load touches the zero flag; literal loads leave it.
	// Holding the flag costs a mux, but code that tests it after a literal load stays valid.
	assign zero_d = capture ? (mem_rd_data == 8'h00) : zero_q;

	// Completion pulse: literal loads at accept, pointer load at capture.
	// An empty opcode is taken but never reports completion, since nothing was done.
	assign done_d = is_bank_lit || is_page_lit || is_acc_lit || capture;

	// Pointer update is issued on the capture cycle, so it lands on the same edge as the data.
	assign ptr_bus.sel = sel_q;
	assign ptr_bus.upd_en = capture && upd_q;
	assign ptr_bus.upd_inc = inc_q;
	assign ptr_bus.wr_en = ptr_wr_en;
	assign ptr_bus.wr_sel = ptr_wr_sel;
	assign ptr_bus.wr_data = ptr_wr_data;

	// Control state.
	// Reset returns to idle, so ready is high as soon as reset is released.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			rd_en_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rd_en_q <= rd_en_d;
			done_q <= done_d;
		end
	end

	// Pending pointer-load context.
	// It lingers between loads, which is harmless: the update only fires in the capture state.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_q <= `PTR_RESET;
			sel_q <= 1'b0;
			upd_q <= 1'b0;
			inc_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			sel_q <= sel_d;
			upd_q <= upd_d;
			inc_q <= inc_d;
		end
	end

	// Architectural registers written by these instructions.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			acc_q <= `ACC_RESET;
			bank_q <= `BANK_RESET;
			page_q <= `PAGE_RESET;
			zero_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			bank_q <= bank_d;
			page_q <= page_d;
			zero_q <= zero_d;
		end
	end

	// Ready is combinational so a new instruction can follow the done pulse directly.
	assign instr_ready = idle;
	assign mem_rd_en = rd_en_q;
	assign mem_addr = addr_q;
	assign pointer0 = ptr_bus.value[0];
	assign pointer1 = ptr_bus.value[1];
	assign accumulator = acc_q;
	assign bank_select_reg = bank_q;
	assign program_counter_high_latch = page_q;
	assign status_zero = zero_q;
	assign instr_done = done_q;
endmodule

// ==== rtl/pointer_unit.sv ====
// Purpose: Holds the two 16-bit pointer registers.
// Assumes: Synchronous active-high reset on ref_clk.
// Notes: Arithmetic is modulo 2^16, so the pointers wrap at both ends.
`include "move_exec_params.svh"
module pointer_unit (
	input wire logic ref_clk,
	input wire logic rst,
	pointer_if.unit bus
);
	import move_exec_pkg::*;

	genvar i;
	generate
		for (i = 0; i < `PTR_COUNT; i++) begin : g_ptr
			logic [`PTR_W-1:0] ptr_q;
			logic [`PTR_W-1:0] ptr_d;
			logic hit_upd;
			logic hit_wr;
			// Decode which request targets this pointer; the update wins a collision.
			assign hit_upd = bus.upd_en && (bus.sel == 1'(i));
			assign hit_wr = bus.wr_en && (bus.wr_sel == 1'(i));
			assign ptr_d = hit_upd ? (bus.upd_inc ? 16'(ptr_q + 16'h0001)
				: 16'(ptr_q - 16'h0001)) : (hit_wr ? bus.wr_data : ptr_q);
			// One register per pointer.
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					ptr_q <= `PTR_RESET;
				end else begin
					ptr_q <= ptr_d;
				end
			end
			assign bus.value[i] = ptr_q;
		end
	endgenerate
endmodule

// ==== verification/literal_indirect_move_exec_test.sv ====
// Purpose: Self-checking bench for the move executor against a plain model.
// Assumes: Inputs change at the falling edge only.
// Notes: Pointer writes happen only while no instruction is pending.
`include "move_exec_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end
module literal_indirect_move_exec_test;
	timeunit 1ns;
	timeprecision 1ns;
	import move_exec_pkg::*;
	logic ref_clk = 0, rst = 1, instr_valid = 0, ptr_select = 0, offset_form = 0;
	logic ptr_wr_en = 0, ptr_wr_sel = 0, mem_rd_en, instr_ready, status_zero, instr_done;
	op_t instr_op = OP_NONE;
	logic [1:0] update_mode = 0;
	logic [5:0] offset = 0, bank_select_reg, bank_m = 0;
	logic [6:0] program_counter_high_latch, page_m = 0;
	logic [7:0] literal = 0, mem_rd_data = 0, accumulator, acc_m = 0;
	logic [15:0] ptr_wr_data = 0, mem_addr, pointer0, pointer1, p0_m = 0, p1_m = 0;
	logic z_m = 0;
	logic [31:0] r;
	int seed = 32'hFC59;
	op_t op_r = OP_NONE;
	logic [7:0] lit_r = 0;
	int failures = 0, checks = 0;
	literal_indirect_move_exec i_literal_indirect_move_exec (.*);
	// Free-running clock at 20 MHz.
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check_all;
		`CHK("acc", acc_m, accumulator)
		`CHK("bank", bank_m, bank_select_reg)
		`CHK("page", page_m, program_counter_high_latch)
		`CHK("zero", z_m, status_zero)
		`CHK("ptr0", p0_m, pointer0)
		`CHK("ptr1", p1_m, pointer1)
	endtask
	task automatic write_ptr(input logic s, input logic [15:0] v);
		instr_valid = 0;
		ptr_wr_en = 1;
		ptr_wr_sel = s;
		ptr_wr_data = v;
		@(negedge ref_clk);
		if (s) p1_m = v;
		else p0_m = v;
	endtask
	// Presents one instruction, answers its read and checks the model afterwards.
	task automatic run(input op_t op, input logic s, input logic [1:0] m, input logic of,
		input logic [5:0] k, input logic [7:0] lit);
		logic [15:0] p, ea;
		logic [7:0] d;
		int n;
		p = s ? p1_m : p0_m;
		ea = of ? p + {{10{k[5]}}, k} : (m == 2'h0 ? p + 16'h1 : (m == 2'h1 ? p - 16'h1 : p));
		r = $random(seed);
		d = r[9:8] == 2'h0 ? 8'h00 : r[7:0];
		n = 0;
		ptr_wr_en = 0;
		instr_valid = 1;
		instr_op = op;
		ptr_select = s;
		update_mode = m;
		offset_form = of;
		offset = k;
		literal = lit;
		@(negedge ref_clk);
		if (op == OP_LOAD_VIA_POINTER) begin
			`CHK("rd_en", 1'b1, mem_rd_en)
			`CHK("addr", ea, mem_addr)
			`CHK("busy", 1'b0, instr_ready)
			mem_rd_data = d;
			while (instr_done !== 1'b1 && n < 4) begin
				@(negedge ref_clk);
				n++;
			end
			mem_rd_data = ~d;
			acc_m = d;
			z_m = d == 8'h00;
			if (!of) p = m[0] ? p - 16'h1 : p + 16'h1;
			if (s) p1_m = p;
			else p0_m = p;
			`CHK("latency", 2, n)
		end else if (op == OP_LOAD_ACC_LITERAL) acc_m = lit;
		else if (op == OP_LOAD_BANK_LITERAL) bank_m = lit[5:0];
		else if (op == OP_LOAD_PAGE_LITERAL) page_m = lit[6:0];
		`CHK("done", op != OP_NONE, instr_done)
		`CHK("ready", 1'b1, instr_ready)
		if (n == 4) print_verdict;
		else check_all;
	endtask
	// Reset, then directed corners, back-to-back literals and random traffic.
	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 0;
		// Let one edge see reset low before the first instruction is offered.
		@(negedge ref_clk);
		check_all;
		for (int i = 0; i < 8; i++) run(OP_LOAD_VIA_POINTER, i[0], 2'(i >> 1), 0, 0, 0);
		run(OP_LOAD_VIA_POINTER, 0, 2'h3, 0, 0, 0);
		write_ptr(0, 16'hFFFF);
		run(OP_LOAD_VIA_POINTER, 0, 2'h0, 0, 0, 0);
		write_ptr(1, 16'h1000);
		run(OP_LOAD_VIA_POINTER, 1, 2'h1, 1, 6'h20, 0);
		run(OP_LOAD_VIA_POINTER, 1, 2'h0, 1, 6'h1F, 0);
		run(OP_LOAD_ACC_LITERAL, 0, 2'h0, 0, 0, 8'hA5);
		run(OP_LOAD_ACC_LITERAL, 0, 2'h0, 0, 0, 8'h00);
		for (int i = 0; i < 120; i++) begin
			r = $random(seed);
			op_r = op_t'(r[18:16] % 3'h5);
			// The producer zero-fills literal bits that the target register does not hold.
			lit_r = op_r == OP_LOAD_BANK_LITERAL ? {2'h0, r[5:0]}
				: op_r == OP_LOAD_PAGE_LITERAL ? {1'h0, r[6:0]} : r[7:0];
			if (r[31:30] == 2'h0) write_ptr(r[29], r[15:0]);
			else run(op_r, r[19], r[21:20], r[22], r[28:23], lit_r);
		end
		instr_valid = 0;
		ptr_wr_en = 0;
		print_verdict;
	end
endmodule

// ==== verification/move_exec_asserts.sv ====
// Purpose: Port-level assertions for the move executor.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Nothing may write a pointer while a pointer load is pending.
`include "move_exec_params.svh"
module move_exec_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire move_exec_pkg::op_t instr_op,
	input wire logic ptr_select,
	input wire logic [1:0] update_mode,
	input wire logic offset_form,
	input wire logic [`OFFSET_W-1:0] offset,
	input wire logic [`DATA_W-1:0] literal,
	input wire logic mem_rd_en,
	input wire logic [`PTR_W-1:0] mem_addr,
	input wire logic [`DATA_W-1:0] mem_rd_data,
	input wire logic [`PTR_W-1:0] pointer0,
	input wire logic [`PTR_W-1:0] pointer1,
	input wire logic [`DATA_W-1:0] accumulator,
	input wire logic [`BANK_W-1:0] bank_select_reg,
	input wire logic [`PAGE_W-1:0] program_counter_high_latch,
	input wire logic status_zero,
	input wire logic instr_done
);
	timeunit 1ns;
	timeprecision 1ns;
	import move_exec_pkg::*;
	// Take events and pointer arithmetic; the 16-bit sums wrap by themselves.
	wire logic take = instr_valid && instr_ready;
	wire logic ptr_take = take && instr_op == OP_LOAD_VIA_POINTER;
	wire logic lit_take = take && instr_op > OP_LOAD_VIA_POINTER;
	wire logic [`PTR_W-1:0] sel_ptr = ptr_select ? pointer1 : pointer0;
	wire logic [`PTR_W-1:0] ptr_next = update_mode[0] ? sel_ptr - 16'h1 : sel_ptr + 16'h1;
	wire logic [`PTR_W-1:0] off_ext = {{(`PTR_W-`OFFSET_W){offset[`OFFSET_W-1]}}, offset};
	wire logic [`PTR_W-1:0] off_addr = sel_ptr + off_ext;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Literal loads land one cycle after the take and leave the flag alone.
	property p_acc;
		take && instr_op == OP_LOAD_ACC_LITERAL |=> instr_done && accumulator == $past(literal);
	endproperty
	a_acc: assert property (p_acc) else $error("Accumulator literal wrong.");
	property p_bank;
		take && instr_op == OP_LOAD_BANK_LITERAL |=> bank_select_reg == ($past(literal) & 8'h3F);
	endproperty
	a_bank: assert property (p_bank) else $error("Bank literal wrong.");
	property p_page;
		take && instr_op == OP_LOAD_PAGE_LITERAL
			|=> program_counter_high_latch == ($past(literal) & 8'h7F);
	endproperty
	a_page: assert property (p_page) else $error("Page literal wrong.");
	property p_flag;
		lit_take |=> $stable(status_zero);
	endproperty
	a_flag: assert property (p_flag) else $error("Literal load moved the flag.");
	// Pointer load: read pulse, two busy cycles, then completion.
	property p_seq;
		ptr_take |=> mem_rd_en && !instr_ready ##1 !mem_rd_en && !instr_ready
			##1 instr_done && instr_ready;
	endproperty
	a_seq: assert property (p_seq) else $error("Pointer load sequence wrong.");
	property p_post;
		ptr_take && !offset_form && update_mode[1] |=> mem_addr == $past(sel_ptr);
	endproperty
	a_post: assert property (p_post) else $error("Post-mode address wrong.");
	// Pre modes address the already moved pointer, wrapping at both ends.
	property p_pre;
		ptr_take && !offset_form && !update_mode[1] |=> mem_addr == $past(ptr_next);
	endproperty
	a_pre: assert property (p_pre) else $error("Pre-mode address wrong.");
	property p_off;
		ptr_take && offset_form |=> mem_addr == $past(off_addr);
	endproperty
	a_off: assert property (p_off) else $error("Offset address wrong.");
	property p_keep;
		ptr_take && offset_form |-> ##3 pointer0 == $past(pointer0, 3)
			&& pointer1 == $past(pointer1, 3);
	endproperty
	a_keep: assert property (p_keep) else $error("Offset load moved a pointer.");
	property p_data;
		ptr_take |-> ##3 accumulator == $past(mem_rd_data)
			&& status_zero == (accumulator == 8'h00);
	endproperty
	a_data: assert property (p_data) else $error("Loaded byte or flag wrong.");
	property p_upd;
		ptr_take && !offset_form
			|-> ##3 ($past(ptr_select, 3) ? pointer1 : pointer0) == $past(ptr_next, 3);
	endproperty
	a_upd: assert property (p_upd) else $error("Pointer update wrong.");
	c_ptr: cover property (ptr_take && !offset_form);
	c_off: cover property (ptr_take && offset_form);
	c_b2b: cover property (lit_take ##1 lit_take);
endmodule
bind literal_indirect_move_exec move_exec_asserts i_move_exec_asserts (.*);
